/* File: src/hpp_defines.vh */
`ifndef HPP_DEFINES_VH
`define HPP_DEFINES_VH

// host data width codes
`define HPP_WIDTH_8 2'h0
`define HPP_WIDTH_16 2'h1
`define HPP_WIDTH_32 2'h2

// byte lane masks
`define HPP_LANES_NONE 4'h0
`define HPP_LANES_8 4'h1
`define HPP_LANES_16 4'h3
`define HPP_LANES_32 4'hF
`define HPP_LANES_HALF_LO 4'h3
`define HPP_LANES_HALF_HI 4'hC

// word and field widths
`define HPP_DATA_ZERO 32'h0000_0000
`define HPP_ADDR_ZERO 9'h000
`define HPP_HALF_ZERO 16'h0000
`define HPP_BYTE_ZERO 24'h00_0000
`define HPP_STROBES_IDLE 4'hF

// interrupt retrigger gap, in clocks
`define HPP_RETRIG_CLKS 3'h5
`define HPP_RETRIG_LAST 3'h0
`define HPP_RETRIG_STEP 3'h1

`endif

/* File: src/hpp_lane_map.v */
`timescale 1ns/100ps
`default_nettype none
`include "hpp_defines.vh"

module hpp_lane_map (
  input wire [1:0] width_in,      // host data width code
  input wire big_endian_in,       // endian select level
  input wire addr1_in,            // low address bit a1 (narrow widths)
  input wire addr0_in,            // low address bit a0 (8-bit width)
  input wire [3:0] strobe_n_in,   // effective lane write strobes
  input wire [31:0] host_data_in, // data from host pins
  input wire [31:0] word_rd_in,   // internal word being read
  output reg [3:0] byte_en_out,   // internal byte enables
  output reg [31:0] word_wr_out,  // data placed on internal lanes
  output reg [31:0] host_rd_out,  // read data placed on host lanes
  output reg [3:0] lanes_out      // host lanes driven on a read
);

  reg upper_half;
  reg [1:0] byte_lane;
  reg [1:0] host_half_en;
  reg [3:0] byte_mask;

  always @* begin
    upper_half = addr1_in ^ big_endian_in;
    byte_lane = {addr1_in, addr0_in} ^ {big_endian_in, big_endian_in};
    host_half_en = ~strobe_n_in[1:0];
    byte_mask = strobe_n_in[0] ? `HPP_LANES_NONE : (`HPP_LANES_8 << byte_lane);
    byte_en_out = `HPP_LANES_NONE;
    word_wr_out = host_data_in;
    host_rd_out = word_rd_in;
    lanes_out = `HPP_LANES_32;
    case (width_in)
      `HPP_WIDTH_32: begin
        byte_en_out = ~strobe_n_in;
      end
      `HPP_WIDTH_16: begin
        byte_en_out = upper_half ? {host_half_en, 2'h0} : {2'h0, host_half_en};
        word_wr_out = {host_data_in[15:0], host_data_in[15:0]};
        host_rd_out = {`HPP_HALF_ZERO, upper_half ? word_rd_in[31:16] : word_rd_in[15:0]};
        lanes_out = `HPP_LANES_16;
      end
      `HPP_WIDTH_8: begin
        byte_en_out = byte_mask;
        word_wr_out = {4{host_data_in[7:0]}};
        host_rd_out = {`HPP_BYTE_ZERO, word_rd_in[byte_lane*8 +: 8]};
        lanes_out = `HPP_LANES_8;
      end
      default: begin
        byte_en_out = `HPP_LANES_NONE;
        lanes_out = `HPP_LANES_NONE;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: src/hpp_irq_line.v */
`timescale 1ns/100ps
`default_nettype none
`include "hpp_defines.vh"

module hpp_irq_line (
  input wire clk_in,     // core clock
  input wire rst_n_in,   // async reset, active low
  input wire trig_in,    // enabled trigger condition, pulse
  input wire pend_in,    // other factors still pending, level
  input wire clear_in,   // designated register accessed, pulse
  output wire irq_n_out  // interrupt line, active low
);

  localparam ST_IDLE = 3'h1;
  localparam ST_LOW = 3'h2;
  localparam ST_GAP = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;
  reg irq_n_q;

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (trig_in) begin
          state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        // a trigger in the clearing cycle keeps the line low
        if (clear_in && !trig_in) begin
          if (pend_in) begin
            state_d = ST_GAP;
            cnt_d = `HPP_RETRIG_CLKS - `HPP_RETRIG_STEP;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (cnt_q == `HPP_RETRIG_LAST) begin
          state_d = ST_LOW;
        end else begin
          cnt_d = cnt_q - `HPP_RETRIG_STEP;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      cnt_q <= `HPP_RETRIG_LAST;
      irq_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      irq_n_q <= (state_d != ST_LOW);
    end
  end

  assign irq_n_out = irq_n_q;

endmodule
`default_nettype wire

/* File: src/hpp_port_top.v */
// Summary of operation
// - both width selects low give 8-bit, D0-D7
// - top strobe pin is endian select when narrow
// - middle strobe pins are A1/A0 in 8-bit
// - read only while chip select and read low
// - read data driven at selected width
// - write stored when select or strobe rises
// - registers word aligned, narrow lanes follow endian
// - shared memory areas handled as 32-bit words
// - three active-low interrupt outputs, high in reset
// - enabled trigger drives its interrupt output low
// - interrupt output released by designated register access
// - shared line retriggers low after 5 clocks
// - lo high alone gives 16-bit, hi high gives 32-bit
// - 32-bit four strobes, 16-bit two lower strobes
`timescale 1ns/100ps
`default_nettype none
`include "hpp_defines.vh"

module hpp_port_top (
  input wire CORE_CLK_IN,                 // core clock, 200 MHz
  input wire RESET_N_IN,                  // async reset, active low
  input wire WIDTH_SELECT_LO_IN,          // width select, low bit
  input wire WIDTH_SELECT_HI_IN,          // width select, high bit
  input wire CS_N_IN,                     // chip select, active low
  input wire RD_N_IN,                     // read strobe, active low
  input wire WRITE_STROBE_LANE3_N_IN,     // lane3 strobe or endian select
  input wire WRITE_STROBE_LANE2_N_IN,     // lane2 strobe or address A1
  input wire WRITE_STROBE_LANE1_N_IN,     // lane1 strobe or address A0
  input wire WRITE_STROBE_LANE0_N_IN,     // lane0 write strobe
  input wire [8:0] ADDR_IN,               // host address A10..A2
  input wire [31:0] DATA_IN,              // data pins, input side
  output wire [31:0] DATA_OUT,            // data pins, output side
  output wire [3:0] DATA_OE_OUT,          // per-lane output enable
  output wire [8:0] MEM_ADDR_OUT,         // internal word address
  output wire MEM_RD_OUT,                 // internal read request
  input wire [31:0] MEM_RDATA_IN,         // internal read data
  output wire MEM_WR_OUT,                 // internal write pulse
  output wire [3:0] MEM_WBE_OUT,          // internal byte enables
  output wire [31:0] MEM_WDATA_OUT,       // internal write data
  output wire BIG_ENDIAN_OUT,             // endian select in effect
  output wire [1:0] WIDTH_OUT,            // width code in effect
  input wire [2:0] IRQ_TRIG_IN,           // trigger pulses per line
  input wire [2:0] IRQ_PEND_IN,           // further factors pending
  input wire [2:0] IRQ_CLEAR_IN,          // clearing register access
  output wire IRQ_OUT0_N_OUT,             // interrupt line 0
  output wire IRQ_OUT1_N_OUT,             // interrupt line 1
  output wire IRQ_OUT2_N_OUT              // interrupt line 2
);

  ////////////////////////////////////////////////////////////////////////

  function [1:0] width_decode;
    input lo;
    input hi;
    begin
      if (hi) begin
        width_decode = `HPP_WIDTH_32;
      end else if (lo) begin
        width_decode = `HPP_WIDTH_16;
      end else begin
        width_decode = `HPP_WIDTH_8;
      end
    end
  endfunction

  function [3:0] strobe_select;
    input [1:0] width;
    input [3:0] pins_n;
    begin
      case (width)
        `HPP_WIDTH_32: strobe_select = pins_n;
        `HPP_WIDTH_16: strobe_select = {2'h3, pins_n[1:0]};
        `HPP_WIDTH_8: strobe_select = {3'h7, pins_n[0]};
        default: strobe_select = `HPP_STROBES_IDLE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////

  wire [1:0] width;
  wire [3:0] pins_n;
  wire [3:0] strobe_n;
  wire big_endian;
  wire addr1;
  wire addr0;
  wire rd_act;
  wire wr_act;
  wire [3:0] map_be;
  wire [31:0] map_wdata;
  wire [31:0] map_rdata;
  wire [3:0] map_lanes;

  assign width = width_decode(WIDTH_SELECT_LO_IN, WIDTH_SELECT_HI_IN);
  assign pins_n = {WRITE_STROBE_LANE3_N_IN, WRITE_STROBE_LANE2_N_IN,
                   WRITE_STROBE_LANE1_N_IN, WRITE_STROBE_LANE0_N_IN};
  assign strobe_n = strobe_select(width, pins_n);
  // shared pins take their narrow-width meaning
  assign big_endian = (width != `HPP_WIDTH_32) && WRITE_STROBE_LANE3_N_IN;
  assign addr1 = (width != `HPP_WIDTH_32) && WRITE_STROBE_LANE2_N_IN;
  assign addr0 = (width == `HPP_WIDTH_8) && WRITE_STROBE_LANE1_N_IN;

  assign rd_act = !CS_N_IN && !RD_N_IN;
  assign wr_act = !CS_N_IN && (strobe_n != `HPP_STROBES_IDLE) && RD_N_IN;

  hpp_lane_map u_lane_map (
    .width_in(width),
    .big_endian_in(big_endian),
    .addr1_in(addr1),
    .addr0_in(addr0),
    .strobe_n_in(strobe_n),
    .host_data_in(DATA_IN),
    .word_rd_in(MEM_RDATA_IN),
    .byte_en_out(map_be),
    .word_wr_out(map_wdata),
    .host_rd_out(map_rdata),
    .lanes_out(map_lanes)
  );

  ////////////////////////////////////////////////////////////////////////
  // access tracking

  reg rd_act_q;
  reg wr_act_q;
  reg [8:0] addr_q;
  reg [31:0] dout_q;
  reg [3:0] oe_q;
  reg wr_pulse_q;
  reg [3:0] acc_be_q;
  reg [31:0] acc_data_q;
  reg [3:0] wbe_q;
  reg [31:0] wdata_q;
  reg big_q;
  reg [1:0] width_q;
  reg [31:0] acc_data_d;
  integer i;

  always @* begin
    acc_data_d = acc_data_q;
    for (i = 0; i < 4; i = i + 1) begin
      if (map_be[i]) begin
        acc_data_d[i*8 +: 8] = map_wdata[i*8 +: 8];
      end
    end
  end

  always @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      addr_q <= `HPP_ADDR_ZERO;
      dout_q <= `HPP_DATA_ZERO;
      oe_q <= `HPP_LANES_NONE;
      wr_pulse_q <= 1'b0;
      acc_be_q <= `HPP_LANES_NONE;
      acc_data_q <= `HPP_DATA_ZERO;
      wbe_q <= `HPP_LANES_NONE;
      wdata_q <= `HPP_DATA_ZERO;
      big_q <= 1'b0;
      width_q <= `HPP_WIDTH_8;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      big_q <= big_endian;
      width_q <= width;
      if (rd_act || wr_act) begin
        addr_q <= ADDR_IN;
      end
      if (rd_act_q) begin
        dout_q <= map_rdata;
      end
      // drive only while the read is still recognised
      if (rd_act && rd_act_q) begin
        oe_q <= map_lanes;
      end else begin
        oe_q <= `HPP_LANES_NONE;
      end
      if (wr_act) begin
        acc_be_q <= acc_be_q | map_be;
        acc_data_q <= acc_data_d;
      end else begin
        acc_be_q <= `HPP_LANES_NONE;
      end
      // store when select or strobe returns high
      wr_pulse_q <= wr_act_q && !wr_act;
      if (wr_act_q && !wr_act) begin
        wbe_q <= acc_be_q;
        wdata_q <= acc_data_q;
      end
    end
  end

  assign DATA_OUT = dout_q;
  assign DATA_OE_OUT = oe_q;
  assign MEM_ADDR_OUT = addr_q;
  assign MEM_RD_OUT = rd_act_q;
  assign MEM_WR_OUT = wr_pulse_q;
  assign MEM_WBE_OUT = wbe_q;
  assign MEM_WDATA_OUT = wdata_q;
  assign BIG_ENDIAN_OUT = big_q;
  assign WIDTH_OUT = width_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupt lines

  wire [2:0] irq_n;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_irq
      hpp_irq_line u_irq (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .trig_in(IRQ_TRIG_IN[g]),
        .pend_in(IRQ_PEND_IN[g]),
        .clear_in(IRQ_CLEAR_IN[g]),
        .irq_n_out(irq_n[g])
      );
    end
  endgenerate

  assign IRQ_OUT0_N_OUT = irq_n[0];
  assign IRQ_OUT1_N_OUT = irq_n[1];
  assign IRQ_OUT2_N_OUT = irq_n[2];

endmodule
`default_nettype wire

/* File: test/hpp_port_props.sv */
`timescale 1ns/100ps
`default_nettype none
module hpp_port_props (
  input wire logic CORE_CLK_IN, // clock
  input wire logic RESET_N_IN, // reset
  input wire logic WIDTH_SELECT_LO_IN, // width
  input wire logic WIDTH_SELECT_HI_IN, // width
  input wire logic CS_N_IN, // select
  input wire logic RD_N_IN, // read
  input wire logic WRITE_STROBE_LANE3_N_IN, // pin
  input wire logic WRITE_STROBE_LANE2_N_IN, // pin
  input wire logic WRITE_STROBE_LANE1_N_IN, // pin
  input wire logic WRITE_STROBE_LANE0_N_IN, // pin
  input wire logic [3:0] DATA_OE_OUT, // enables
  input wire logic MEM_RD_OUT, // read
  input wire logic MEM_WR_OUT, // write
  input wire logic [2:0] IRQ_TRIG_IN, // trigger
  input wire logic [2:0] IRQ_PEND_IN, // pending
  input wire logic [2:0] IRQ_CLEAR_IN, // clear
  input wire logic IRQ_OUT0_N_OUT // line
);
  wire hi = WIDTH_SELECT_HI_IN;
  wire lo = WIDTH_SELECT_LO_IN;
  wire [3:0] sn = {WRITE_STROBE_LANE3_N_IN, WRITE_STROBE_LANE2_N_IN,
                   WRITE_STROBE_LANE1_N_IN, WRITE_STROBE_LANE0_N_IN};
  wire rd = !CS_N_IN && !RD_N_IN;
  wire wr = !CS_N_IN && RD_N_IN && (hi ? !(&sn) : lo ? !(&sn[1:0]) : !sn[0]);
  wire [3:0] m = hi ? 4'hF : lo ? 4'h3 : 4'h1;
  wire q = IRQ_OUT0_N_OUT;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence wr_end;
    wr ##1 !wr;
  endsequence
  sequence clr_pend;
    !q && IRQ_CLEAR_IN[0] && IRQ_PEND_IN[0] && !IRQ_TRIG_IN[0];
  endsequence
  a_rd_seen: assert property (rd |=> MEM_RD_OUT) else $error("read missed");
  a_oe_off: assert property (CS_N_IN || RD_N_IN |=> DATA_OE_OUT == 4'h0)
    else $error("bus driven");
  a_oe_width: assert property (rd [*2] |=> DATA_OE_OUT == m)
    else $error("bad lanes");
  a_wr_commit: assert property (wr_end |-> ##[1:2] MEM_WR_OUT ##1 !MEM_WR_OUT)
    else $error("write lost");
  a_wr_cause: assert property (MEM_WR_OUT |-> $past(wr, 2) || $past(wr, 3))
    else $error("stray write");
  a_irq_fall: assert property (IRQ_TRIG_IN[0] |=> !q) else $error("no irq");
  a_irq_hold: assert property (!q && !IRQ_CLEAR_IN[0] |=> !q)
    else $error("irq dropped");
  a_irq_retrig: assert property (clr_pend |=> q [*5] ##1 !q)
    else $error("bad retrigger");
endmodule
`default_nettype wire

/* File: test/hpp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hpp_host_model (
  input wire logic clk_in, // clock
  input wire logic [31:0] bus_in, // data wire
  output logic cs_n_out, // select
  output logic rd_n_out, // read
  output logic [3:0] s_n_out, // shared pins
  output logic [8:0] a_out, // address
  output logic [31:0] d_out // data
);
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    s_n_out = 4'hF;
    a_out = 9'h000;
    d_out = 32'h0000_0000;
  end
  task automatic access(input logic [1:0] w, input logic e, wr, sel, input logic [3:0] l,
                        input logic [10:0] a, input logic [31:0] d, output logic [31:0] q);
    @(negedge clk_in);
    a_out = a[10:2];
    d_out = wr ? d : ~d_out; // inverted while reading
    s_n_out = w[1] ? ~(l & {4{wr}}) : {e, a[1], w[0] ? ~(l[1] & wr) : a[0], ~(l[0] & wr)};
    rd_n_out = wr;
    cs_n_out = ~sel;
    repeat (wr ? 18 : 26) @(posedge clk_in);
    q = bus_in;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    s_n_out = {e | w[1], 3'h7};
    d_out = ~d_out;
    repeat (9) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: test/hpp_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module hpp_port_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wlo = 1'b0;
  logic whi = 1'b0;
  logic [2:0] trig = 3'h0;
  logic [2:0] pend = 3'h0;
  logic [2:0] clr = 3'h0;
  wire cs_n, rd_n, mrd, mwr, big;
  wire [3:0] s_n, oe, wbe;
  wire [8:0] ha, ma;
  wire [31:0] hd, dout, mwd, din, bus, oem;
  wire [1:0] wo;
  wire [2:0] irq_n;
  logic [31:0] mem [0:511];
  int ref_m [0:511];
  int err_count = 0;
  int cmp_count = 0;
  int wseen = 0;
  int cyc = 0;
  int seed = 32'h22fe;
  logic [3:0] lbe = 4'h0;
  logic [31:0] lwd = 32'h0000_0000;
  always #2.5 clk = ~clk;
  assign oem = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
  assign bus = (dout & oem) | (hd & ~oem);
  assign din = bus & (whi ? 32'hFFFF_FFFF : wlo ? 32'h0000_FFFF : 32'h0000_00FF);
  hpp_port_top dut_u (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .WIDTH_SELECT_LO_IN(wlo),
    .WIDTH_SELECT_HI_IN(whi), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
    .WRITE_STROBE_LANE3_N_IN(s_n[3]), .WRITE_STROBE_LANE2_N_IN(s_n[2]),
    .WRITE_STROBE_LANE1_N_IN(s_n[1]), .WRITE_STROBE_LANE0_N_IN(s_n[0]), .ADDR_IN(ha),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(oe), .MEM_ADDR_OUT(ma), .MEM_RD_OUT(mrd),
    .MEM_RDATA_IN(mem[ma]), .MEM_WR_OUT(mwr), .MEM_WBE_OUT(wbe), .MEM_WDATA_OUT(mwd),
    .BIG_ENDIAN_OUT(big), .WIDTH_OUT(wo), .IRQ_TRIG_IN(trig), .IRQ_PEND_IN(pend),
    .IRQ_CLEAR_IN(clr), .IRQ_OUT0_N_OUT(irq_n[0]), .IRQ_OUT1_N_OUT(irq_n[1]),
    .IRQ_OUT2_N_OUT(irq_n[2]));
  hpp_host_model host_u (.clk_in(clk), .bus_in(bus), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .s_n_out(s_n), .a_out(ha), .d_out(hd));
  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ex(input logic [3:0] l);
    ex = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  always @(posedge clk) begin
    if (mwr === 1'b1) begin
      for (int i = 0; i < 4; i++)
        if (wbe[i]) mem[ma][8*i+:8] <= mwd[8*i+:8];
      lbe <= wbe;
      lwd <= mwd;
      wseen <= wseen + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic op(input logic [1:0] w, input logic e, wr, sel, input logic [3:0] l,
                    input logic [10:0] a, input logic [31:0] d);
    logic [31:0] q, m, bm;
    int s, n;
    n = wseen;
    s = w[1] ? 0 : w[0] ? 16 * (a[1] ^ e) : 8 * ({a[1], a[0]} ^ {e, e});
    l = w[1] ? l : w[0] ? l & 4'h3 : 4'h1;
    if (l == 4'h0) l = 4'h1;
    m = ex(l) << s;
    bm = ex(w[1] ? 4'hF : w[0] ? 4'h3 : 4'h1);
    host_u.access(w, e, wr, sel, l, a, d, q);
    if (wr) chk(wseen, n + sel);
    if (wr && sel) begin
      chk(lbe, l << (s / 8));
      chk(lwd & m, (d << s) & m);
      ref_m[a[10:2]] = (ref_m[a[10:2]] & ~m) | ((d << s) & m);
    end
    if (!wr && sel) chk(q & bm, (ref_m[a[10:2]] >> s) & bm);
  endtask
  task automatic pulse(input int n, input logic t, c, p);
    @(negedge clk);
    trig[n] = t;
    clr[n] = c;
    pend[n] = p;
    @(negedge clk);
    trig[n] = 1'b0;
    clr[n] = 1'b0;
  endtask
  initial begin
    logic [1:0] w;
    logic e;
    logic [10:0] a;
    for (int i = 0; i < 512; i++) begin
      mem[i] = $random(seed);
      ref_m[i] = mem[i];
    end
    repeat (3) @(posedge clk);
    chk(irq_n, 3'h7);
    chk(oe, 4'h0);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (84) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      w = k;
      @(negedge clk);
      {whi, wlo} = w;
      repeat (12) begin
        e = w[1] ? 1'b0 : $random(seed);
        a = $random(seed);
        op(w, e, 1'b1, 1'b1, $random(seed), a, $random(seed));
        op(w, e, 1'b0, 1'b1, 4'h0, a, 32'h0000_0000);
        op(w, e, $random(seed), 1'b0, 4'hF, a, $random(seed));
        op(w, e, 1'b0, 1'b1, 4'h0, a, 32'h0000_0000);
        chk(big, e & !w[1]);
        chk(wo, w);
      end
    end
    for (int n = 0; n < 3; n++) begin
      pulse(n, 1'b1, 1'b0, 1'b0);
      chk(irq_n[n], 1'b0);
      pulse(n, 1'b0, 1'b1, 1'b1);
      chk(irq_n[n], 1'b1);
      repeat (6) @(negedge clk);
      chk(irq_n[n], 1'b0);
      pulse(n, 1'b0, 1'b1, 1'b0);
      repeat (8) @(negedge clk);
      chk(irq_n[n], 1'b1);
    end
    report_and_stop();
  end
endmodule
bind hpp_port_top hpp_port_props props_u (.CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN),
  .WIDTH_SELECT_LO_IN(WIDTH_SELECT_LO_IN), .WIDTH_SELECT_HI_IN(WIDTH_SELECT_HI_IN),
  .CS_N_IN(CS_N_IN), .RD_N_IN(RD_N_IN), .WRITE_STROBE_LANE3_N_IN(WRITE_STROBE_LANE3_N_IN),
  .WRITE_STROBE_LANE2_N_IN(WRITE_STROBE_LANE2_N_IN),
  .WRITE_STROBE_LANE1_N_IN(WRITE_STROBE_LANE1_N_IN),
  .WRITE_STROBE_LANE0_N_IN(WRITE_STROBE_LANE0_N_IN), .DATA_OE_OUT(DATA_OE_OUT),
  .MEM_RD_OUT(MEM_RD_OUT), .MEM_WR_OUT(MEM_WR_OUT), .IRQ_TRIG_IN(IRQ_TRIG_IN),
  .IRQ_PEND_IN(IRQ_PEND_IN), .IRQ_CLEAR_IN(IRQ_CLEAR_IN), .IRQ_OUT0_N_OUT(IRQ_OUT0_N_OUT));
`default_nettype wire
